// ---- rtl/fbmc_pkg.sv ----
// Purpose: Shared constants and types for the flash bus mode controller
// Assumes: 250 MHz clock, byte-wide parallel flash with active-low strobes
// Notes: Timing figures are kept in ns and converted to cycles here
`default_nettype none
package fbmc_pkg;
   localparam int CLK_PERIOD_NS = 4;
   // Address access time and automatic sleep margin
   localparam int ACCESS_TIME_NS = 90;
   localparam int SLEEP_MARGIN_NS = 30;
   // Least strobe low time, kept well above the glitch limit
   localparam int GLITCH_LIMIT_NS = 5;
   localparam int STROBE_LOW_NS = 40;
   localparam int SETUP_NS = 8;
   localparam int STROBE_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GLITCH_CYC = (GLITCH_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC =
      (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
   localparam int SLEEP_CYC =
      (ACCESS_TIME_NS + SLEEP_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_STROBE = 8'(STROBE_CYC);
   localparam logic [7:0] CNT_SETUP = 8'(SETUP_CYC);
   localparam logic [7:0] CNT_READ = 8'(READ_CYC);
   // Status bit positions
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int TIMEOUT_BIT = 5;
   // Sector field of the address
   localparam int SECTOR_HI = 18;
   localparam int SECTOR_LO = 16;
   localparam logic [7:0] RESET_CMD = 8'hF0;
   localparam logic [18:0] ADDR_RESET = 19'h00000;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef enum logic [2:0] {
      FBMC_IDLE = 3'b000,
      FBMC_WSETUP = 3'b001,
      FBMC_WSTROBE = 3'b010,
      FBMC_WHOLD = 3'b011,
      FBMC_RSTROBE = 3'b100,
      FBMC_RDONE = 3'b101
   } fbmc_state_e;

   // User-side request
   typedef struct packed {
      logic write;
      logic [18:0] addr;
      logic [7:0] data;
   } fbmc_req_s;

   // Flash pins driven by the controller
   typedef struct packed {
      logic chipEnN;
      logic outEnN;
      logic writeEnN;
      logic [18:0] addr;
      logic [7:0] dqOut;
      logic dqOe;
   } fbmc_pins_s;
endpackage : fbmc_pkg
`default_nettype wire

// ---- rtl/fbmc_host.sv ----
// Purpose: Host-side controller driving a parallel flash over its strobes
// Assumes: One clock; flash data input comes from another domain
// Notes: Issues single read and write cycles; status is decoded per read
`default_nettype none
module fbmc_host
   import fbmc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic reqValid,
   input wire fbmc_req_s req,
   output logic reqReady,
   output logic rspValid,
   output logic [7:0] rspData,
   output logic rspDone,
   output logic rspToggling,
   output logic rspTimeout,
   output logic [2:0] rspSector,
   output fbmc_pins_s pins,
   input wire logic [7:0] dqIn
);
   // ****************************************
   // Input synchroniser for the data bus
   // ****************************************
   logic [7:0] dqMeta_r;
   logic [7:0] dqSync_r;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dqMeta_r <= DATA_RESET;
         dqSync_r <= DATA_RESET;
      end else begin
         dqMeta_r <= dqIn;
         dqSync_r <= dqMeta_r;
      end
   end

   // ****************************************
   // Cycle sequencer
   // ****************************************
   fbmc_state_e state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   fbmc_pins_s pins_r, pins_nxt;
   logic [7:0] lastRead_r, lastRead_nxt;
   logic haveLast_r, haveLast_nxt;
   logic rspValid_r, rspValid_nxt;
   logic [7:0] rspData_r, rspData_nxt;
   logic rspDone_r, rspDone_nxt;
   logic rspToggling_r, rspToggling_nxt;
   logic rspTimeout_r, rspTimeout_nxt;
   logic [2:0] rspSector_r, rspSector_nxt;
   logic ready_r, ready_nxt;
   logic [18:0] lastAddr_r, lastAddr_nxt;

   // Next-state logic for strobes, data and status decode
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      pins_nxt = pins_r;
      lastRead_nxt = lastRead_r;
      haveLast_nxt = haveLast_r;
      rspValid_nxt = 1'b0;
      rspData_nxt = rspData_r;
      rspDone_nxt = rspDone_r;
      rspToggling_nxt = rspToggling_r;
      rspTimeout_nxt = rspTimeout_r;
      rspSector_nxt = rspSector_r;
      ready_nxt = 1'b0;
      lastAddr_nxt = lastAddr_r;
      case (state_r)
         FBMC_IDLE: begin
            ready_nxt = 1'b1;
            if (reqValid && ready_r) begin
               ready_nxt = 1'b0;
               pins_nxt.addr = req.addr;
               pins_nxt.chipEnN = 1'b1;
               pins_nxt.outEnN = 1'b1;
               pins_nxt.writeEnN = 1'b1;
               cnt_nxt = CNT_SETUP;
               if (req.addr != lastAddr_r) begin
                  haveLast_nxt = 1'b0;
               end
               lastAddr_nxt = req.addr;
               if (req.write) begin
                  // Output enable high before driving data
                  pins_nxt.dqOut = req.data;
                  state_nxt = FBMC_WSETUP;
               end else begin
                  pins_nxt.dqOe = 1'b0;
                  state_nxt = FBMC_RSTROBE;
                  pins_nxt.chipEnN = 1'b0;
                  pins_nxt.outEnN = 1'b0;
                  cnt_nxt = CNT_READ;
               end
            end
         end
         FBMC_WSETUP: begin
            pins_nxt.dqOe = 1'b1;
            if (cnt_r == CNT_ZERO) begin
               pins_nxt.chipEnN = 1'b0;
               pins_nxt.writeEnN = 1'b0;
               cnt_nxt = CNT_STROBE;
               state_nxt = FBMC_WSTROBE;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         FBMC_WSTROBE: begin
            if (cnt_r == CNT_ZERO) begin
               pins_nxt.writeEnN = 1'b1;
               cnt_nxt = CNT_SETUP;
               state_nxt = FBMC_WHOLD;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         FBMC_WHOLD: begin
            if (cnt_r == CNT_ZERO) begin
               pins_nxt.chipEnN = 1'b1;
               pins_nxt.dqOe = 1'b0;
               rspValid_nxt = 1'b1;
               state_nxt = FBMC_IDLE;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         FBMC_RSTROBE: begin
            if (cnt_r == CNT_ZERO) begin
               state_nxt = FBMC_RDONE;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         FBMC_RDONE: begin
            // Sample, then release strobes; compare with prior read
            pins_nxt.outEnN = 1'b1;
            pins_nxt.chipEnN = 1'b1;
            rspData_nxt = dqSync_r;
            rspToggling_nxt = haveLast_r &&
               (dqSync_r[TOGGLE_BIT] != lastRead_r[TOGGLE_BIT]);
            rspDone_nxt = !rspToggling_nxt;
            rspTimeout_nxt = rspToggling_nxt && dqSync_r[TIMEOUT_BIT];
            rspSector_nxt = pins_r.addr[SECTOR_HI:SECTOR_LO];
            lastRead_nxt = dqSync_r;
            haveLast_nxt = 1'b1;
            rspValid_nxt = 1'b1;
            state_nxt = FBMC_IDLE;
         end
         default: begin
            state_nxt = FBMC_IDLE;
         end
      endcase
   end

   // Registers of the sequencer
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= FBMC_IDLE;
         cnt_r <= CNT_ZERO;
         // Strobes held high in reset so no write forms at power-up
         pins_r <= '{chipEnN: 1'b1, outEnN: 1'b1, writeEnN: 1'b1,
                     addr: ADDR_RESET, dqOut: DATA_RESET, dqOe: 1'b0};
         lastRead_r <= DATA_RESET;
         haveLast_r <= 1'b0;
         rspValid_r <= 1'b0;
         rspData_r <= DATA_RESET;
         rspDone_r <= 1'b0;
         rspToggling_r <= 1'b0;
         rspTimeout_r <= 1'b0;
         rspSector_r <= 3'h0;
         ready_r <= 1'b0;
         lastAddr_r <= ADDR_RESET;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         pins_r <= pins_nxt;
         lastRead_r <= lastRead_nxt;
         haveLast_r <= haveLast_nxt;
         rspValid_r <= rspValid_nxt;
         rspData_r <= rspData_nxt;
         rspDone_r <= rspDone_nxt;
         rspToggling_r <= rspToggling_nxt;
         rspTimeout_r <= rspTimeout_nxt;
         rspSector_r <= rspSector_nxt;
         ready_r <= ready_nxt;
         lastAddr_r <= lastAddr_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign pins = pins_r;
   assign reqReady = ready_r;
   assign rspValid = rspValid_r;
   assign rspData = rspData_r;
   assign rspDone = rspDone_r;
   assign rspToggling = rspToggling_r;
   assign rspTimeout = rspTimeout_r;
   assign rspSector = rspSector_r;

   // ****************************************
   // Checks on driven pins and response flags
   // ****************************************
   AST_WRITE_LEVELS: assert property (@(posedge clock) disable iff (reset)
      !pins_r.writeEnN |-> (!pins_r.chipEnN && pins_r.outEnN))
      else $error("write strobe without valid enables");
   AST_NO_CONTENTION: assert property (@(posedge clock) disable iff (reset)
      pins_r.dqOe |-> pins_r.outEnN)
      else $error("host drives data while output enabled");
   AST_WE_WIDTH: assert property (@(posedge clock) disable iff (reset)
      $fell(pins_r.writeEnN) |-> !pins_r.writeEnN [*8])
      else $error("write pulse too short");
   AST_ADDR_STABLE: assert property (@(posedge clock) disable iff (reset)
      !pins_r.writeEnN |=> $stable(pins_r.addr))
      else $error("address moved during write strobe");
   AST_DATA_HOLD: assert property (@(posedge clock) disable iff (reset)
      $rose(pins_r.writeEnN) && state_r == FBMC_WHOLD |-> pins_r.dqOe && !pins_r.chipEnN)
      else $error("data not held past write rising edge");
   AST_READ_LEN: assert property (@(posedge clock) disable iff (reset)
      $fell(pins_r.outEnN) |-> !pins_r.outEnN [*8] ##[1:40] rspValid_r)
      else $error("read strobe ended early or no response");
   AST_WRITE_DONE: assert property (@(posedge clock) disable iff (reset)
      $rose(pins_r.writeEnN) |-> ##[1:10] pins_r.chipEnN)
      else $error("chip enable not released after write");
   AST_TIMEOUT: assert property (@(posedge clock) disable iff (reset)
      rspTimeout_r |-> !rspDone_r && rspToggling_r && rspData_r[TIMEOUT_BIT])
      else $error("timeout flagged with done");
   AST_READ_ADDR: assert property (@(posedge clock) disable iff (reset)
      (!pins_r.outEnN && !pins_r.chipEnN) |=> $stable(pins_r.addr))
      else $error("address moved during read strobe");
endmodule : fbmc_host
`default_nettype wire

// ---- testbench/fbmc_flash_model.sv ----
// Purpose: Behavioural byte-wide flash answering the host controller
// Assumes: Active-low strobes; read data moves one clock after the pins
// Notes: Only program, identification and reset commands are decoded
`default_nettype none
module fbmc_flash_model
   import fbmc_pkg::*;
#(
   parameter logic [7:0] PROT_MASK = 8'h80,
   parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] DEV_CODE = 8'hA6, // Arbitrary value
   parameter int BUSY_CYC = 100
)(
   input wire logic clock,
   input wire fbmc_pins_s pins,
   output logic [7:0] dqIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [18:0]];
   logic [18:0] wAddr = 19'h00000;
   logic [7:0] lastData = 8'h00;
   logic idMode = 1'b0; // Array reads from power-up
   logic tog = 1'b0;
   logic timedOut = 1'b0; // Program ran out of time, held until reset
   logic elevatedIdVoltage = 1'b0; // Id address pin at elevated level
   int step = 0;
   int busy = 0;
   realtime tFall = 0.0;
   wire logic wStrobe = pins.chipEnN | pins.writeEnN;

   function automatic logic [7:0] arrayByte(logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : arrayByte

   // Address on the later falling strobe
   always @(negedge wStrobe) begin
      wAddr = pins.addr;
      tFall = $realtime;
   end

   // ****************************************
   // Command decoder on the first rising strobe
   // ****************************************
   always @(posedge wStrobe) begin
      if (pins.outEnN === 1'b1 && (busy == 0 || timedOut) && $realtime > 50.0
          && $realtime - tFall >= 5.0) begin
         if (step == 3) begin
            // Program data first, so an F0 data byte is not a reset
            if (!PROT_MASK[wAddr[18:16]]) begin
               timedOut = (~arrayByte(wAddr) & pins.dqOut) != 8'h00;
               mem[wAddr] = arrayByte(wAddr) & pins.dqOut;
               lastData = pins.dqOut;
               busy = BUSY_CYC;
            end
            step = 0;
         end else if (pins.dqOut == 8'hF0) begin
            step = 0;
            idMode = 1'b0;
            timedOut = 1'b0;
            busy = 0;
         end else if (pins.dqOut == 8'hAA && wAddr[10:0] == 11'h555) begin
            step = 1;
         end else if (step == 1 && pins.dqOut == 8'h55 && wAddr[10:0] == 11'h2AA) begin
            step = 2;
         end else if (step == 2 && pins.dqOut == 8'hA0) begin
            step = 3;
         end else if (step == 2 && pins.dqOut == 8'h90) begin
            idMode = 1'b1;
            step = 0;
         end else begin
            step = 0;
         end
      end
   end

   // Toggle bit flips on every read while busy
   always @(negedge pins.outEnN) if (pins.chipEnN === 1'b0 && busy > 0) tog = ~tog;

   // Output bus churns when released, else status, code or array byte
   initial dqIn = 8'h3C;
   always @(posedge clock) begin
      if (busy > 0 && !timedOut) busy--;
      if (pins.chipEnN || pins.outEnN) begin
         dqIn <= ~dqIn;
      end else if (busy > 0) begin
         dqIn <= {~lastData[7], tog, timedOut, 5'h00};
      end else if (idMode || elevatedIdVoltage) begin
         dqIn <= (pins.addr[1:0] == 2'h2) ? {7'h00, PROT_MASK[pins.addr[18:16]]}
            : (pins.addr[0] ? DEV_CODE : MAKER_CODE);
      end else begin
         dqIn <= arrayByte(pins.addr);
      end
   end
endmodule : fbmc_flash_model
`default_nettype wire

// ---- testbench/fbmc_host_tb_top.sv ----
// Purpose: Self-checking bench of the host controller against a flash model
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Program addresses and data come from a seeded xorshift
`default_nettype none
module fbmc_host_tb_top
   import fbmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic reqValid = 1'b0;
   fbmc_req_s req = '0;
   logic reqReady, rspValid, rspDone, rspToggling, rspTimeout;
   logic [7:0] rspData, dqIn, d;
   logic [2:0] rspSector;
   logic [18:0] a;
   fbmc_pins_s pins;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000AF1D;

   always #2 clock = ~clock;

   fbmc_host i_dut (.clock(clock), .reset(reset), .reqValid(reqValid), .req(req),
      .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspDone(rspDone),
      .rspToggling(rspToggling), .rspTimeout(rspTimeout), .rspSector(rspSector),
      .pins(pins), .dqIn(dqIn));
   fbmc_flash_model #(.MAKER_CODE(MAKER)) i_flash (.clock(clock), .pins(pins), .dqIn(dqIn));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xorshift

   // Polling bit while busy is the inverse of the programmed bit 7
   function automatic logic [7:0] pollByte(logic [7:0] dt);
      return {7'h00, ~dt[7]};
   endfunction : pollByte

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic access(logic wr, logic [18:0] ad, logic [7:0] dt);
      while (reqReady !== 1'b1) begin
         @(posedge clock);
         #1;
      end
      req = '{wr, ad, dt};
      reqValid = 1'b1;
      @(posedge clock);
      #1;
      reqValid = 1'b0;
      while (rspValid !== 1'b1) begin
         @(posedge clock);
         #1;
      end
   endtask : access

   task automatic unlock(logic [7:0] cmd);
      access(1'b1, 19'h00555, 8'hAA);
      access(1'b1, 19'h002AA, 8'h55);
      access(1'b1, 19'h00555, cmd);
   endtask : unlock

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   // Strobe levels of every write cycle, no drive while outputs enabled
   always @(posedge clock) begin
      if (!reset && pins.writeEnN === 1'b0) check("write strobes",
         {6'h00, pins.chipEnN, pins.outEnN}, 8'h01);
      if (!reset && pins.outEnN === 1'b0) check("read drive", {7'h00, pins.dqOe}, 8'h00);
   end

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles > 6000) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      repeat (10) @(posedge clock);
      #1 reset = 1'b0;
      access(1'b0, 19'h12345, 8'h00);
      check("power-up read", rspData, 8'hFF);
      $display("Test power-up done");
      for (int i = 0; i < 3; i++) begin
         a = {3'(xorshift() % 7), 16'(xorshift())};
         // Bit 0 kept low so a later all-ones program must time out
         d = 8'(xorshift()) & 8'hFE;
         unlock(8'hA0);
         access(1'b1, a, d);
         access(1'b0, a, 8'h00);
         check("poll bit", {7'h00, rspData[7]}, pollByte(d));
         access(1'b0, a, 8'h00);
         check("toggling", {7'h00, rspToggling}, 8'h01);
         for (int k = 0; k < 8 && rspDone !== 1'b1; k++) access(1'b0, a, 8'h00);
         access(1'b0, a, 8'h00);
         check("programmed", rspData, d);
         check("sector", {5'h00, rspSector}, {5'h00, a[18:16]});
         $display("Test program %0d done", i);
      end
      // Programming a one over a zero times out until the reset command
      unlock(8'hA0);
      access(1'b1, a, 8'hFF);
      access(1'b0, a, 8'h00);
      access(1'b0, a, 8'h00);
      check("timeout", {7'h00, rspTimeout}, 8'h01);
      check("timeout done", {7'h00, rspDone}, 8'h00);
      access(1'b1, 19'h00000, RESET_CMD);
      access(1'b0, a, 8'h00);
      check("after timeout", rspData, d);
      check("timeout clear", {7'h00, rspTimeout}, 8'h00);
      $display("Test timeout done");
      unlock(8'hA0);
      access(1'b1, 19'h70042, 8'h00);
      access(1'b0, 19'h70042, 8'h00);
      check("protected", rspData, 8'hFF);
      unlock(8'h90);
      access(1'b0, 19'h00000, 8'h00);
      check("maker code", rspData, MAKER);
      access(1'b0, 19'h70002, 8'h00);
      check("protect flag", rspData, 8'h01);
      access(1'b0, 19'h30002, 8'h00);
      check("open flag", rspData, 8'h00);
      access(1'b1, 19'h00000, 8'hF0);
      access(1'b0, 19'h12345, 8'h00);
      check("array again", rspData, 8'hFF);
      // Programmer style identification by elevated level on the id pin
      i_flash.elevatedIdVoltage = 1'b1;
      access(1'b0, 19'h00100, 8'h00);
      check("voltage maker code", rspData, MAKER);
      i_flash.elevatedIdVoltage = 1'b0;
      access(1'b0, 19'h00100, 8'h00);
      check("voltage removed", rspData, 8'hFF);
      $display("Test identification done");
      end_of_test();
   end
endmodule : fbmc_host_tb_top
`default_nettype wire
